// File: rtl/tsw_pkg.sv
// shared constants and types of the slot switch host port
package tsw_pkg;
  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int NSTR = 32;
  localparam int NCH = 512;
  localparam int STR_W = 5;
  localparam int CH_W = 9;
  localparam int BIT_W = 3;
  localparam int FCNT_W = 12;
  localparam int AW = 16;
  localparam int DW = 16;
  localparam int CM_DEPTH = NSTR * NCH;
  localparam int DM_DEPTH = 2 * NSTR * NCH;
  localparam int FMT_STABLE = 8;
  // ---------------------------------------------------------------
  // device address map, top two address bits pick the region
  // ---------------------------------------------------------------
  localparam logic [1:0] RGN_CM0 = 2'h0;
  localparam logic [1:0] RGN_CM1 = 2'h1;
  localparam logic [1:0] RGN_DM = 2'h2;
  localparam logic [1:0] RGN_REG = 2'h3;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_FDLY = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam int CTL_STANDBY = 0;
  localparam logic [DW-1:0] CTRL_RST = 16'h0000;
  // connection memory entry fields
  localparam int CM_HIZ = 14;
  localparam int CM_CONST = 15;
  // ---------------------------------------------------------------
  // controller registers on apb
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RDATA = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int HC_RDGO = 0;
  localparam int HC_RESET = 1;
  localparam int HC_GATE = 2;
  localparam int HS_BUSY = 0;
  localparam int HS_RDONE = 1;
  localparam int HS_EMPTY = 2;
  localparam int HS_FULL = 3;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int RESET_MIN_NS = 20;
  localparam int RESET_CYC_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC = (RESET_CYC_RAW < 1) ? 1 : RESET_CYC_RAW;
  localparam int FIFO_DEPTH = 8;
  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    AC_IDLE = 2'b00,
    AC_ACT = 2'b01,
    AC_ACK = 2'b11,
    AC_REL = 2'b10
  } tsw_acc_t;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SETUP = 2'b01,
    HS_STRB = 2'b11,
    HS_WREL = 2'b10
  } tsw_hst_t;
endpackage

// File: rtl/tsw_host_if.sv
// pins between the host controller and the switch
`timescale 1ns/100ps
`default_nettype none
interface tsw_host_if;
  import tsw_pkg::*;
  logic cs_n;
  logic host_strobe_n;
  logic rd_wr;
  logic [AW-1:0] host_addr;
  logic [DW-1:0] hd_host;
  logic hd_host_oe_n;
  logic [DW-1:0] hd_dev;
  logic hd_dev_oe_n;
  logic [DW-1:0] host_data;
  logic ack_dev;
  logic ack_oe_n;
  logic transfer_ack;
  logic dev_reset_n;
  logic tx_drive_gate;
  // wire levels; undriven lines rest high as on a pulled-up bus
  assign host_data = !hd_dev_oe_n ? hd_dev : (!hd_host_oe_n ? hd_host : '1);
  assign transfer_ack = ack_oe_n ? 1'b1 : ack_dev;
  modport host (
    output cs_n, host_strobe_n, rd_wr, host_addr, hd_host, hd_host_oe_n,
    output dev_reset_n, tx_drive_gate,
    input host_data, transfer_ack
  );
  modport dev (
    input cs_n, host_strobe_n, rd_wr, host_addr, host_data, dev_reset_n, tx_drive_gate,
    output hd_dev, hd_dev_oe_n, ack_dev, ack_oe_n
  );
endinterface
`default_nettype wire

// File: rtl/tsw_dev_end.sv
// switch end: host port, memories, serial streams and output gating
//
// Contract
// - port ignored while select is high
// - transfer only with strobe and select low
// - read-write pin sets data bus direction
// - acknowledge driven high then released
// - address reaches every internal memory
// - gate low, standby low: outputs float
// - gate high enables serial output drivers
// - per-channel float bit still floats channel
// - reset clears state, floats outputs, bus
// - reset held low at least 20 ns
// - frame pulse format sensed automatically
// - frame evaluation delay measured against pulse
// - streams shifted on serial clock
// - 32 input and 32 output streams
// - any input channel to any output
// - per-channel variable or constant delay
`timescale 1ns/100ps
`default_nettype none
module tsw_dev_end
  import tsw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  tsw_host_if.dev hif,
  input wire logic serial_clock_in,
  input wire logic frame_sync_in,
  input wire logic frame_eval_in,
  input wire logic [NSTR-1:0] rx_streams,
  output logic [NSTR-1:0] serial_out_streams,
  output logic [NSTR-1:0] serial_out_oe_n
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic int dm_idx(input logic bank, input logic [STR_W-1:0] s,
                                input logic [CH_W-1:0] c);
    dm_idx = int'({bank, s, c});
  endfunction

  logic clr;
  assign clr = !hif.dev_reset_n;

  // ---------------------------------------------------------------
  // memories
  // ---------------------------------------------------------------
  logic [7:0] dmem [DM_DEPTH];
  logic [DW-1:0] cmem [CM_DEPTH];

  // ---------------------------------------------------------------
  // serial clock, frame pulse sensing, counters
  // ---------------------------------------------------------------
  logic sclk_r;
  logic srise;
  logic sync_d_r;
  logic fmt_high_r;
  logic [3:0] stab_r;
  logic fstart;
  logic [FCNT_W-1:0] fcnt_r;
  logic bank_r;
  logic [CH_W-1:0] ch;
  logic [2:0] bitn;
  logic [CH_W-1:0] next_ch;

  assign srise = serial_clock_in && !sclk_r;
  assign fstart = srise && (frame_sync_in == fmt_high_r) && (sync_d_r != fmt_high_r);
  assign ch = fcnt_r[FCNT_W-1:BIT_W];
  assign bitn = fcnt_r[BIT_W-1:0];
  assign next_ch = ch + 9'h001;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_r <= 1'b0;
      sync_d_r <= 1'b1;
    end else begin
      sclk_r <= serial_clock_in;
      if (srise) begin
        sync_d_r <= frame_sync_in;
      end
    end
  end

  // the level that rests long is the idle level; the pulse is the other one
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stab_r <= 4'h0;
      fmt_high_r <= 1'b0;
    end else if (clr) begin
      stab_r <= 4'h0;
      fmt_high_r <= 1'b0;
    end else if (srise) begin
      if (frame_sync_in != sync_d_r) begin
        stab_r <= 4'h0;
      end else if (stab_r != 4'(FMT_STABLE)) begin
        stab_r <= stab_r + 4'h1;
      end else begin
        fmt_high_r <= !frame_sync_in;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fcnt_r <= '0;
      bank_r <= 1'b0;
    end else if (clr) begin
      fcnt_r <= '0;
      bank_r <= 1'b0;
    end else if (fstart) begin
      fcnt_r <= '0;
      bank_r <= !bank_r;
    end else if (srise) begin
      fcnt_r <= fcnt_r + 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // frame evaluation delay
  // ---------------------------------------------------------------
  logic fe_d_r;
  logic fe_seen_r;
  logic [FCNT_W-1:0] fe_cnt_r;
  logic [FCNT_W-1:0] fe_dly_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fe_d_r <= 1'b0;
      fe_seen_r <= 1'b0;
      fe_cnt_r <= '0;
      fe_dly_r <= '0;
    end else if (clr) begin
      fe_d_r <= 1'b0;
      fe_seen_r <= 1'b0;
      fe_cnt_r <= '0;
      fe_dly_r <= '0;
    end else if (srise) begin
      fe_d_r <= frame_eval_in;
      if (fstart) begin
        fe_cnt_r <= '0;
        fe_seen_r <= 1'b0;
      end else begin
        fe_cnt_r <= fe_cnt_r + 12'h001;
        if (frame_eval_in && !fe_d_r && !fe_seen_r) begin
          fe_dly_r <= fe_cnt_r;
          fe_seen_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // receive side: shift in, store per frame bank
  // ---------------------------------------------------------------
  logic [6:0] rx_sh_r [NSTR];

  always_ff @(posedge sys_clk) begin
    if (srise) begin
      for (int s = 0; s < NSTR; s++) begin
        rx_sh_r[s] <= {rx_sh_r[s][5:0], rx_streams[s]};
        if (bitn == 3'h7) begin
          dmem[dm_idx(bank_r, STR_W'(s), ch)] <= {rx_sh_r[s], rx_streams[s]};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // host port
  // ---------------------------------------------------------------
  tsw_acc_t st_r;
  logic [AW-1:0] addr_r;
  logic rd_r;
  logic [DW-1:0] ctrl_r;
  logic sel_ok;
  logic [1:0] rgn;
  logic [DW-1:0] rd_val;

  assign sel_ok = !hif.cs_n && !hif.host_strobe_n;
  assign rgn = addr_r[AW-1:AW-2];

  always_comb begin
    rd_val = '0;
    unique case (rgn)
      RGN_CM0, RGN_CM1: rd_val = cmem[addr_r[STR_W+CH_W-1:0]];
      RGN_DM: rd_val = {8'h00, dmem[dm_idx(!bank_r, addr_r[13:9], addr_r[8:0])]};
      RGN_REG: begin
        if (addr_r[1:0] == REG_CTRL) begin
          rd_val = ctrl_r;
        end else if (addr_r[1:0] == REG_FDLY) begin
          rd_val = {4'h0, fe_dly_r};
        end else if (addr_r[1:0] == REG_STAT) begin
          rd_val = {14'h0000, bank_r, fmt_high_r};
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= AC_IDLE;
      addr_r <= '0;
      rd_r <= 1'b1;
      hif.hd_dev <= '0;
      hif.hd_dev_oe_n <= 1'b1;
      hif.ack_dev <= 1'b1;
      hif.ack_oe_n <= 1'b1;
    end else if (clr) begin
      st_r <= AC_IDLE;
      hif.hd_dev_oe_n <= 1'b1;
      hif.ack_dev <= 1'b1;
      hif.ack_oe_n <= 1'b1;
    end else begin
      unique case (st_r)
        AC_IDLE: begin
          if (sel_ok) begin
            addr_r <= hif.host_addr;
            rd_r <= hif.rd_wr;
            st_r <= AC_ACT;
          end
        end
        AC_ACT: begin
          hif.hd_dev <= rd_val;
          hif.hd_dev_oe_n <= !rd_r;
          hif.ack_dev <= 1'b0;
          hif.ack_oe_n <= 1'b0;
          st_r <= AC_ACK;
        end
        AC_ACK: begin
          if (hif.cs_n || hif.host_strobe_n) begin
            hif.hd_dev_oe_n <= 1'b1;
            hif.ack_dev <= 1'b1;
            st_r <= AC_REL;
          end
        end
        AC_REL: begin
          hif.ack_oe_n <= 1'b1;
          st_r <= AC_IDLE;
        end
      endcase
    end
  end

  // writes land one cycle after the strobe is seen, data then settled
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
    end else if (clr) begin
      ctrl_r <= CTRL_RST;
    end else if (st_r == AC_ACT && !rd_r && rgn == RGN_REG && addr_r[1:0] == REG_CTRL) begin
      ctrl_r <= hif.host_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (st_r == AC_ACT && !rd_r && !clr && (rgn == RGN_CM0 || rgn == RGN_CM1)) begin
      cmem[addr_r[STR_W+CH_W-1:0]] <= hif.host_data;
    end
  end

  // ---------------------------------------------------------------
  // transmit side
  // ---------------------------------------------------------------
  logic [7:0] tx_sh_r [NSTR];
  logic [NSTR-1:0] ch_hiz_r;
  logic drive_on;

  assign drive_on = hif.tx_drive_gate || ctrl_r[CTL_STANDBY];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int s = 0; s < NSTR; s++) begin
        tx_sh_r[s] <= 8'h00;
      end
      ch_hiz_r <= '1;
    end else if (clr) begin
      ch_hiz_r <= '1;
    end else if (srise) begin
      for (int s = 0; s < NSTR; s++) begin
        if (bitn == 3'h7) begin
          logic [DW-1:0] ent;
          ent = cmem[{STR_W'(s), next_ch}];
          // constant delay reads last frame's bank, variable the live one
          tx_sh_r[s] <= dmem[dm_idx(ent[CM_CONST] ? !bank_r : bank_r,
                                   ent[13:9], ent[8:0])];
          ch_hiz_r[s] <= ent[CM_HIZ];
        end else begin
          tx_sh_r[s] <= {tx_sh_r[s][6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_out_streams <= '0;
      serial_out_oe_n <= '1;
    end else if (clr) begin
      serial_out_oe_n <= '1;
    end else begin
      for (int s = 0; s < NSTR; s++) begin
        serial_out_streams[s] <= tx_sh_r[s][7];
        serial_out_oe_n[s] <= !drive_on || ch_hiz_r[s];
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/tsw_host_end.sv
// host end: write fifo and the apb-driven port controller
`timescale 1ns/100ps
`default_nettype none
module tsw_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

module tsw_host_end
  import tsw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  tsw_host_if.host hif
);
  // ---------------------------------------------------------------
  // apb slave, one wait state so every answer comes from a flop
  // ---------------------------------------------------------------
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  logic [DW-1:0] f_data;
  logic acc;
  logic fire;
  logic mapped;
  logic [31:0] rval;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] rdata_r;
  logic rd_req_r;
  logic rd_done_r;
  logic gate_r;
  logic [3:0] rst_cnt_r;
  tsw_hst_t st_r;
  logic cur_rd_r;

  assign acc = psel && penable;
  assign fire = acc && pready;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) || (paddr == OFS_WDATA)
               || (paddr == OFS_RDATA) || (paddr == OFS_STAT);

  always_comb begin
    rval = 32'h00000000;
    unique case (paddr)
      OFS_CTRL: rval[HC_GATE] = gate_r;
      OFS_ADDR: rval[AW-1:0] = addr_r;
      OFS_RDATA: rval[DW-1:0] = rdata_r;
      OFS_STAT: begin
        rval[HS_BUSY] = (st_r != HS_IDLE) || rd_req_r || f_out_valid;
        rval[HS_RDONE] = rd_done_r;
        rval[HS_EMPTY] = !f_out_valid;
        rval[HS_FULL] = !f_in_ready;
      end
      default: rval = 32'h00000000;
    endcase
  end

  // a data push waits for room: the fifo stalls the bus, not drops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (acc && !pready) begin
      if (!(pwrite && paddr == OFS_WDATA && !f_in_ready)) begin
        pready <= 1'b1;
        pslverr <= !mapped;
        prdata <= pwrite ? 32'h00000000 : rval;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  tsw_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_wfifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(fire && pwrite && paddr == OFS_WDATA),
    .in_ready(f_in_ready),
    .in_data(pwdata[DW-1:0]),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gate_r <= 1'b0;
      rst_cnt_r <= 4'h0;
      hif.tx_drive_gate <= 1'b0;
      hif.dev_reset_n <= 1'b0;
    end else begin
      hif.tx_drive_gate <= gate_r;
      hif.dev_reset_n <= (rst_cnt_r == 4'h0);
      if (rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
      end
      if (fire && pwrite && paddr == OFS_CTRL) begin
        gate_r <= pwdata[HC_GATE];
        if (pwdata[HC_RESET]) begin
          rst_cnt_r <= 4'(RESET_CYC);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pin sequencer; a read request beats queued writes
  // ---------------------------------------------------------------
  assign f_pop = (st_r == HS_IDLE) && !rd_req_r && f_out_valid && hif.dev_reset_n;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= HS_IDLE;
      addr_r <= '0;
      rdata_r <= '0;
      rd_req_r <= 1'b0;
      rd_done_r <= 1'b0;
      cur_rd_r <= 1'b1;
      hif.cs_n <= 1'b1;
      hif.host_strobe_n <= 1'b1;
      hif.rd_wr <= 1'b1;
      hif.host_addr <= '0;
      hif.hd_host <= '0;
      hif.hd_host_oe_n <= 1'b1;
    end else begin
      if (fire && pwrite && paddr == OFS_ADDR) begin
        addr_r <= pwdata[AW-1:0];
      end
      if (fire && pwrite && paddr == OFS_CTRL && pwdata[HC_RDGO]) begin
        rd_req_r <= 1'b1;
        rd_done_r <= 1'b0;
      end
      unique case (st_r)
        HS_IDLE: begin
          if (hif.dev_reset_n && (rd_req_r || f_out_valid)) begin
            cur_rd_r <= rd_req_r;
            hif.rd_wr <= rd_req_r;
            hif.host_addr <= addr_r;
            hif.hd_host <= f_data;
            hif.hd_host_oe_n <= rd_req_r;
            hif.cs_n <= 1'b0;
            rd_req_r <= 1'b0;
            st_r <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          hif.host_strobe_n <= 1'b0;
          st_r <= HS_STRB;
        end
        HS_STRB: begin
          if (!hif.transfer_ack) begin
            if (cur_rd_r) begin
              rdata_r <= hif.host_data;
              rd_done_r <= 1'b1;
            end else begin
              addr_r <= addr_r + 16'h0001;
            end
            hif.host_strobe_n <= 1'b1;
            hif.cs_n <= 1'b1;
            hif.hd_host_oe_n <= 1'b1;
            st_r <= HS_WREL;
          end
        end
        HS_WREL: begin
          // wait for the released ack before the next cycle
          if (hif.transfer_ack) begin
            st_r <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: test/tsw_port_checker.sv
// concurrent checks on the wires between host end and switch end
`timescale 1ns/100ps
`default_nettype none
module tsw_port_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic host_strobe_n,
  input wire logic rd_wr,
  input wire logic hd_dev_oe_n,
  input wire logic ack_oe_n,
  input wire logic transfer_ack,
  input wire logic dev_reset_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------
  // port handshake
  // ------------------------------------------
  a_sel_start: assert property ($fell(transfer_ack) |-> $past(!cs_n && !host_strobe_n))
    else $error("ack fell without select and strobe");
  a_sel_quiet: assert property (cs_n && ack_oe_n |=> ack_oe_n)
    else $error("ack driven while deselected");
  // bound of 4 covers latch edge plus answer edge
  a_ack_timely: assert property ($fell(host_strobe_n) && !cs_n && dev_reset_n
    |-> ##[1:4] !transfer_ack)
    else $error("no ack after strobe");
  a_ack_hold: assert property (!transfer_ack && !cs_n && !host_strobe_n |=> !transfer_ack)
    else $error("ack dropped before strobe removed");
  a_ack_high: assert property ($rose(transfer_ack) |-> !ack_oe_n ##1 ack_oe_n)
    else $error("ack not driven high then released");
  a_ack_release: assert property ($rose(ack_oe_n) |-> $past(transfer_ack))
    else $error("ack released while low");
  // ------------------------------------------
  // bus direction and reset
  // ------------------------------------------
  a_read_drive: assert property (!transfer_ack && !ack_oe_n && rd_wr |-> !hd_dev_oe_n)
    else $error("read ack without data driven");
  a_write_quiet: assert property (!cs_n && !host_strobe_n && !rd_wr |-> hd_dev_oe_n)
    else $error("device drives bus on write");
  a_reset_float: assert property (!dev_reset_n |=> hd_dev_oe_n && ack_oe_n)
    else $error("bus or ack driven in reset");
endmodule
`default_nettype wire

// File: test/tsi_switch_host_port_ctrl_bench.sv
// self-checking bench joining host end and switch end
`timescale 1ns/100ps
`default_nettype none
module tsi_switch_host_port_ctrl_bench;
  import tsw_pkg::*;
  logic sys_clk;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NSTR-1:0] soe_n;
  logic [31:0] rd;
  logic er;
  int err_total;
  int total_checks;
  int cyc;
  logic [15:0] ta [4];
  logic [15:0] tw [4];
  tsw_host_if hif ();
  tsw_host_end tsw_host_end_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hif(hif));
  // serial side tied: only the host port is under test here
  tsw_dev_end tsw_dev_end_inst (.sys_clk(sys_clk), .rst(rst), .hif(hif),
    .serial_clock_in(1'h0), .frame_sync_in(1'h0), .frame_eval_in(1'h0), .rx_streams('0),
    .serial_out_streams(), .serial_out_oe_n(soe_n));
  tsw_port_checker tsw_port_checker_inst (.sys_clk(sys_clk), .rst(rst), .cs_n(hif.cs_n),
    .host_strobe_n(hif.host_strobe_n), .rd_wr(hif.rd_wr), .hd_dev_oe_n(hif.hd_dev_oe_n),
    .ack_oe_n(hif.ack_oe_n), .transfer_ack(hif.transfer_ack), .dev_reset_n(hif.dev_reset_n));
  always #20 sys_clk = ~sys_clk;
  // ------------------------------------------
  // tasks
  // ------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // no fixed latency assumed: waits for pready, timeout cuts a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic poll(input int b, input logic v);
    do apb(1'h0, OFS_STAT, 32'h0); while (rd[b] !== v);
  endtask
  // a queued write bumps ADDR when it lands: wait for it before reloading
  task automatic pwr(input logic [15:0] a, input logic [15:0] d);
    poll(HS_BUSY, 1'h0);
    apb(1'h1, OFS_ADDR, {16'h0, a});
    apb(1'h1, OFS_WDATA, {16'h0, d});
  endtask
  task automatic prd(input logic [15:0] a);
    poll(HS_EMPTY, 1'h1);
    poll(HS_BUSY, 1'h0);
    apb(1'h1, OFS_ADDR, {16'h0, a});
    apb(1'h1, OFS_CTRL, 32'h1);
    poll(HS_RDONE, 1'h1);
    apb(1'h0, OFS_RDATA, 32'h0);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    // regions 0 and 1 share one entry set, so rows avoid aliasing
    ta = '{16'h0005, 16'h3FFF, 16'h4000, 16'h7FFE};
    tw = '{16'h1234, 16'hC0DE, 16'h8001, 16'h4ABC};
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    chk(soe_n, '1);
    for (int i = 0; i < 4; i++) pwr(ta[i], tw[i]);
    for (int i = 0; i < 4; i++) begin
      prd(ta[i]);
      chk(rd, {16'h0, tw[i]});
    end
    // back-to-back pushes ride on the address auto-increment
    apb(1'h1, OFS_ADDR, 32'h0100);
    apb(1'h1, OFS_WDATA, 32'h1111);
    apb(1'h1, OFS_WDATA, 32'h2222);
    apb(1'h1, OFS_WDATA, 32'h3333);
    prd(16'h0101);
    chk(rd, 32'h2222);
    prd(16'h0102);
    chk(rd, 32'h3333);
    pwr(16'hC000, 16'h0001);
    prd(16'hC000);
    chk(rd, 32'h1);
    apb(1'h1, OFS_CTRL, 32'h2);
    prd(16'hC000);
    chk(rd, 32'h0);
    prd(16'hC001);
    chk(rd, 32'h0);
    prd(16'hC002);
    chk(rd, 32'h0);
    chk(soe_n, '1);
    apb(1'h1, OFS_CTRL, 32'h4);
    // the pin follows the register one edge late: read back first
    apb(1'h0, OFS_CTRL, 32'h0);
    chk(rd, 32'h4);
    chk({31'h0, hif.tx_drive_gate}, 32'h1);
    apb(1'h1, OFS_CTRL, 32'h0);
    apb(1'h0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
